// [psw_pkg.sv]
package psw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned OC_QUAL_NS    = 2_000;       // 2 us
  localparam int unsigned SWAP_MIN_US   = 600;         // 600 us
  localparam int unsigned SWAP_ON_US    = 60;          // 60 us
  localparam int unsigned DEGLITCH_MS   = 7;           // 7 ms
  localparam int unsigned RETRY_MS      = 128;         // 128 ms

  // Least times round up, longest times round down
  localparam int unsigned OC_QUAL_CYC =
    (OC_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SWAP_MIN_CYC = SWAP_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SWAP_ON_CYC  = SWAP_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC    = RETRY_MS * (CLK_HZ / 1000);

  localparam int unsigned CNT_W = 23;

  // Reset values
  localparam logic RST_GATE  = 1'b0;
  localparam logic RST_FAULT = 1'b1;

  // Enable / role-swap control states
  typedef enum logic [1:0] {
    PSW_OFF     = 2'b00,
    PSW_NORMAL  = 2'b01,
    PSW_SWAP_WT = 2'b10,
    PSW_SWAP_ON = 2'b11
  } psw_mode_e;

endpackage

// [psw_ctrl.sv]
`timescale 1ns/1ps

// Notes on behaviour
// R1: Overtemperature forces gate off immediately
// R2: Thermal recovery uses separate hysteresis comparator
// R3: Overcurrent qualified after 2us continuous; regulate
// R4: Fast trip turns gate off immediately
// R5: Output collapse during limiting turns off
// R6: Short-circuit shutdown auto-retries every 128ms
// R7: Fault flag low after 7ms valid fault
// R8: Flag low, gate off until faults clear
// R9: System pulls fault flag line up externally
// R10: Role-swap rising edge arms swap, any enable
// R11: Pulse over 600us, no reverse: on fast
// R12: Fast turn-on bypasses slow ramp
// R13: Reverse at pulse end: on when cleared
// R14: After swap, ignore enable rise, fall disables
// R15: After shutdown, need new enable/swap rise
// R16: Output discharge only when out ctl high
// R17: Input discharge only when in ctl high
// R18: Both high both discharge; both low none
// R19: Undriven discharge controls treated as low
// R20: Reverse voltage off at once, on when clear
// R21: Input overvoltage turns switch off
// R22: Intervals counted in clock cycles
// R23: Async inputs synchronised before use
module psw_ctrl
  import psw_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  input  wire logic role_swap_trigger_in,
  input  wire logic in_discharge_ctl_in,
  input  wire logic out_discharge_ctl_in,
  input  wire logic over_temp_in,
  input  wire logic temp_recovered_in,
  input  wire logic over_limit_in,
  input  wire logic fast_trip_in,
  input  wire logic out_collapse_in,
  input  wire logic reverse_voltage_in,
  input  wire logic input_overvoltage_in,
  input  wire logic limit_pin_short_in,
  output logic      gate_on_out,
  output logic      fast_ramp_out,
  output logic      current_limit_out,
  output logic      fault_flag_n_out,
  output logic      fault_flag_n_oe_out,
  output logic      in_discharge_out,
  output logic      out_discharge_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NIN = 12;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] flt_reg;

  assign raw_in = {limit_pin_short_in, input_overvoltage_in,
                   reverse_voltage_in, out_collapse_in, fast_trip_in,
                   over_limit_in, temp_recovered_in, over_temp_in,
                   out_discharge_ctl_in, in_discharge_ctl_in,
                   role_swap_trigger_in, enable_in};

  // Three stages; a level changes only when stages two and three agree
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      flt_reg <= '0;
    end else begin
      s1_reg  <= raw_in; // R23
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    end
  end

  // Named synchronised levels
  logic en_s, swap_s, idis_s, odis_s, otp_s, trec_s;
  logic olim_s, ftrip_s, coll_s, rev_s, ovp_s, lps_s;
  assign {lps_s, ovp_s, rev_s, coll_s, ftrip_s, olim_s,
          trec_s, otp_s, odis_s, idis_s, swap_s, en_s} = flt_reg;

  logic en_d_reg;
  logic swap_d_reg;
  logic en_rise, en_fall, swap_rise, swap_fall;
  assign en_rise   = en_s & ~en_d_reg;
  assign en_fall   = ~en_s & en_d_reg;
  assign swap_rise = swap_s & ~swap_d_reg;
  assign swap_fall = ~swap_s & swap_d_reg;

  // ----------------------------------------------------------------
  // Protection state
  // ----------------------------------------------------------------
  logic            thermal_reg;
  logic            oc_reg;
  logic            sc_reg;
  logic [CNT_W-1:0] oc_cnt_reg;
  logic [CNT_W-1:0] retry_cnt_reg;
  logic [CNT_W-1:0] dg_cnt_reg;

  logic oc_qual, sc_trip, retry_done;
  assign oc_qual    = olim_s && (oc_cnt_reg >= CNT_W'(OC_QUAL_CYC)); // R3
  // Collapse only counts while regulating; fast trip does not wait
  assign sc_trip    = ftrip_s | (oc_reg & coll_s); // R4 R5
  assign retry_done = sc_reg && (retry_cnt_reg == CNT_W'(RETRY_CYC - 1));

  // Thermal latch: set by shutdown comparator, cleared by recovery one
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      thermal_reg <= 1'b0;
    end else if (otp_s) begin
      thermal_reg <= 1'b1; // R1
    end else if (trec_s) begin
      thermal_reg <= 1'b0; // R2
    end
  end

  // Over-limit must be continuous; any gap restarts the count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !olim_s) begin
      oc_cnt_reg <= '0;
    end else if (oc_cnt_reg < CNT_W'(OC_QUAL_CYC)) begin
      oc_cnt_reg <= oc_cnt_reg + 1'b1; // R22
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      oc_reg <= 1'b0;
    end else begin
      oc_reg <= oc_qual; // R3
    end
  end

  // Short circuit latches off, then retries each period while it persists
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sc_reg        <= 1'b0;
      retry_cnt_reg <= '0;
    end else if (sc_trip && !sc_reg) begin
      sc_reg        <= 1'b1;
      retry_cnt_reg <= '0;
    end else if (sc_reg) begin
      retry_cnt_reg <= retry_done ? '0 : retry_cnt_reg + 1'b1;
      if (retry_done) begin
        sc_reg <= 1'b0; // R6
      end
    end
  end

  // Any exception that blocks the switch
  logic fault_any, block_any;
  assign fault_any = ovp_s | rev_s | thermal_reg | sc_reg | oc_reg | lps_s;
  assign block_any = ovp_s | rev_s | thermal_reg | sc_reg; // R20 R21

  // ----------------------------------------------------------------
  // Fault flag with deglitch
  // ----------------------------------------------------------------
  // Counter restarts whenever every condition clears, so short blips
  // never reach the flag; this also delays reporting of re-faults.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !fault_any) begin
      dg_cnt_reg <= '0;
    end else if (dg_cnt_reg < CNT_W'(DEGLITCH_CYC)) begin
      dg_cnt_reg <= dg_cnt_reg + 1'b1;
    end
  end

  logic fault_flag_next;
  assign fault_flag_next = ~(fault_any &&
                             dg_cnt_reg >= CNT_W'(DEGLITCH_CYC - 1)); // R7 R8

  // ----------------------------------------------------------------
  // Enable and role-swap sequencing
  // ----------------------------------------------------------------
  psw_mode_e        mode_reg;
  psw_mode_e        mode_next;
  logic [CNT_W-1:0] pw_cnt_reg;
  logic [CNT_W-1:0] on_cnt_reg;
  logic             armed_reg;
  logic             pw_ok;
  assign pw_ok = pw_cnt_reg > CNT_W'(SWAP_MIN_CYC); // R11

  // Pulse width measured from the arming edge
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || swap_rise) begin
      pw_cnt_reg <= '0;
    end else if (swap_s && !pw_ok) begin
      pw_cnt_reg <= pw_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      armed_reg <= 1'b0;
    end else if (swap_rise) begin
      armed_reg <= 1'b1; // R10
    end else if (swap_fall) begin
      armed_reg <= 1'b0;
    end
  end

  // Mode decisions
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      PSW_OFF: begin
        if (en_rise) begin
          mode_next = PSW_NORMAL; // R15
        end
      end
      PSW_NORMAL: begin
        if (!en_s) begin
          mode_next = PSW_OFF;
        end
      end
      PSW_SWAP_WT: begin
        if (!rev_s) begin
          mode_next = PSW_SWAP_ON; // R13
        end
      end
      PSW_SWAP_ON: begin
        if (en_fall) begin
          mode_next = PSW_OFF; // R14
        end
      end
    endcase
    // Role-swap qualification overrides enable level
    if (swap_fall && armed_reg && pw_ok) begin
      mode_next = rev_s ? PSW_SWAP_WT : PSW_SWAP_ON; // R11 R13
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_reg   <= PSW_OFF;
      en_d_reg   <= 1'b0;
      swap_d_reg <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      en_d_reg   <= en_s;
      swap_d_reg <= swap_s;
    end
  end

  // Fast-ramp window after a swap turn-on
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || mode_next != PSW_SWAP_ON) begin
      on_cnt_reg <= '0;
    end else if (on_cnt_reg < CNT_W'(SWAP_ON_CYC)) begin
      on_cnt_reg <= on_cnt_reg + 1'b1;
    end
  end

  logic want_on;
  assign want_on = (mode_next == PSW_NORMAL) || (mode_next == PSW_SWAP_ON);

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Gate stays off while any blocking exception or reported fault holds
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gate_on_out         <= RST_GATE;
      fast_ramp_out       <= 1'b0;
      current_limit_out   <= 1'b0;
      fault_flag_n_out    <= 1'b0;
      fault_flag_n_oe_out <= RST_FAULT;
      in_discharge_out    <= 1'b0;
      out_discharge_out   <= 1'b0;
    end else begin
      gate_on_out   <= want_on && !block_any && !sc_trip && !otp_s &&
                       fault_flag_next; // R1 R4 R8 R20 R21
      fast_ramp_out <= (mode_next == PSW_SWAP_ON) &&
                       (on_cnt_reg < CNT_W'(SWAP_ON_CYC)); // R12
      current_limit_out   <= oc_qual; // R3
      fault_flag_n_out    <= 1'b0;    // Open drain: only pulls low
      fault_flag_n_oe_out <= fault_flag_next; // R7 R9
      in_discharge_out    <= idis_s;  // R17 R18 R19
      out_discharge_out   <= odis_s;  // R16 R18 R19
    end
  end

endmodule

// [psw_pc_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port controller driving the control pins
// ----------------------------------------
module psw_pc_model (
  input  wire logic clk_in,
  input  wire logic flag_in,
  input  wire logic flag_oe_in,
  output logic      enable_out,
  output logic      swap_out,
  output logic      dis_in_out,
  output logic      dis_out_out,
  output wire logic fault_line_out
);
  // Pull-up wins whenever the device lets the line go
  assign fault_line_out = flag_oe_in ? 1'b1 : flag_in;
  // Undriven discharge pins rest low
  initial begin
    enable_out  = 1'b0;
    swap_out    = 1'b0;
    dis_in_out  = 1'b0;
    dis_out_out = 1'b0;
  end
  // Pins change only just after a rising edge
  task automatic set_pins(logic en, logic di, logic dq);
    @(posedge clk_in);
    enable_out  <= en;
    dis_in_out  <= di;
    dis_out_out <= dq;
  endtask
  // Pulse width in clock cycles
  task automatic swap_pulse(int n);
    @(posedge clk_in);
    swap_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    swap_out <= 1'b0;
  endtask
endmodule

// [psw_ctrl_chk.sv]
`timescale 1ns/1ps
module psw_ctrl_chk (
  input wire logic ref_clk_in, rst_in, over_temp_in, fast_trip_in,
  input wire logic reverse_voltage_in, input_overvoltage_in,
  input wire logic over_limit_in, out_collapse_in,
  input wire logic in_discharge_ctl_in, out_discharge_ctl_in,
  input wire logic gate_on_out, fast_ramp_out, current_limit_out,
  input wire logic fault_flag_n_out, fault_flag_n_oe_out,
  input wire logic in_discharge_out, out_discharge_out
);
  // -------------------
  // Output relations
  // -------------------
  // Eight cycles cover the input filter plus the output flop
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  hot_gate_off_a: assert property (over_temp_in[*8] |=> !gate_on_out)
    else $error("gate on while hot");
  trip_gate_off_a: assert property (fast_trip_in[*8] |=> !gate_on_out)
    else $error("gate on during fast trip");
  rev_gate_off_a: assert property (reverse_voltage_in[*8] |=> !gate_on_out)
    else $error("gate on with reverse voltage");
  ovp_gate_off_a: assert property (input_overvoltage_in[*8] |=> !gate_on_out)
    else $error("gate on with input overvoltage");
  limit_qual_a: assert property ($rose(current_limit_out) |->
    $past(over_limit_in, 8) && over_limit_in) else $error("early limit");
  collapse_off_a: assert property (out_collapse_in[*8] ##0 current_limit_out
    |=> !gate_on_out) else $error("gate on after collapse");
  flag_data_a: assert property (!fault_flag_n_out)
    else $error("flag data not low");
  flag_gate_a: assert property (!fault_flag_n_oe_out[*2] |-> !gate_on_out)
    else $error("gate on while flag low");
  ramp_gate_a: assert property ($rose(fast_ramp_out) |-> gate_on_out)
    else $error("fast ramp without gate");
  out_dis_a: assert property (out_discharge_ctl_in[*8] |=> out_discharge_out)
    else $error("output discharge missing");
  in_dis_a: assert property (!in_discharge_ctl_in[*8] |=> !in_discharge_out)
    else $error("input discharge stuck");
endmodule
bind psw_ctrl psw_ctrl_chk i_psw_ctrl_chk (.*);

// [tb_psw_ctrl.sv]
`timescale 1ns/1ps
module tb_psw_ctrl;
  import psw_pkg::*;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, chk_req = 1'b0;
  logic over_temp_in = 1'b0, temp_recovered_in = 1'b1, over_limit_in = 1'b0;
  logic fast_trip_in = 1'b0, out_collapse_in = 1'b0, reverse_voltage_in = 1'b0;
  logic input_overvoltage_in = 1'b0, en, sw, di, dq, fl;
  logic limit_pin_short_in = 1'b0;
  logic gate, ramp, clim, flag, flag_oe, ind, outd;
  logic [4:0]  exp_q[$];
  logic [15:0] lfsr = 16'h0007;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  psw_pc_model i_psw_pc_model (.clk_in(ref_clk_in), .flag_in(flag),
    .flag_oe_in(flag_oe), .enable_out(en), .swap_out(sw), .dis_in_out(di),
    .dis_out_out(dq), .fault_line_out(fl));
  psw_ctrl i_psw_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .enable_in(en), .role_swap_trigger_in(sw), .in_discharge_ctl_in(di),
    .out_discharge_ctl_in(dq), .over_temp_in(over_temp_in),
    .temp_recovered_in(temp_recovered_in), .over_limit_in(over_limit_in),
    .fast_trip_in(fast_trip_in), .out_collapse_in(out_collapse_in),
    .reverse_voltage_in(reverse_voltage_in),
    .limit_pin_short_in(limit_pin_short_in),
    .input_overvoltage_in(input_overvoltage_in), .gate_on_out(gate),
    .fast_ramp_out(ramp), .current_limit_out(clim), .fault_flag_n_out(flag),
    .fault_flag_n_oe_out(flag_oe), .in_discharge_out(ind),
    .out_discharge_out(outd));
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // Note the expectation, then let the watcher compare at the next edge
  task automatic expect_out(logic [4:0] v);
    exp_q.push_back(v);
    chk_req <= 1'b1;
    @(posedge ref_clk_in);
    chk_req <= 1'b0;
  endtask
  task automatic check_val(logic [4:0] seen, logic [4:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: saw %b want %b", $time, seen, want);
    end
  endtask
  task automatic do_reset();
    i_psw_pc_model.set_pins(1'b0, 1'b0, 1'b0);
    rst_in <= 1'b1;
    cycles(10);
    rst_in <= 1'b0;
    cycles(8);
  endtask
  // Watcher pops the oldest note; packed as gate, ramp, limit, in, out
  always @(posedge ref_clk_in) begin
    if (chk_req) check_val({gate, ramp, clim, ind, outd}, exp_q.pop_front());
  end
  // Hang guard sized for three swap pulses plus margin
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 85000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    i_psw_pc_model.set_pins(1'b1, 1'b0, 1'b0);
    cycles(8);
    expect_out(5'h10);
    over_temp_in <= 1'b1;
    temp_recovered_in <= 1'b0;
    cycles(8);
    expect_out(5'h00);
    over_temp_in <= 1'b0;
    cycles(8);
    expect_out(5'h00);
    temp_recovered_in <= 1'b1;
    cycles(8);
    expect_out(5'h10);
    // A shorted limit pin does not block the gate at once, only once the deglitched flag goes low
    limit_pin_short_in <= 1'b1;
    cycles(8);
    expect_out(5'h10);
    limit_pin_short_in <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) reverse_voltage_in <= 1'b1;
      else input_overvoltage_in <= 1'b1;
      cycles(8);
      expect_out(5'h00);
      reverse_voltage_in <= 1'b0;
      input_overvoltage_in <= 1'b0;
      cycles(8);
      expect_out(5'h10);
    end
    over_limit_in <= 1'b1;
    cycles(40);
    over_limit_in <= 1'b0;
    cycles(8);
    expect_out(5'h10);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    over_limit_in <= 1'b1;
    cycles(OC_QUAL_CYC + 10 + int'(lfsr[3:0]));
    expect_out(5'h14);
    out_collapse_in <= 1'b1;
    cycles(12);
    expect_out(5'h04);
    out_collapse_in <= 1'b0;
    over_limit_in <= 1'b0;
    do_reset();
    i_psw_pc_model.set_pins(1'b1, 1'b0, 1'b0);
    fast_trip_in <= 1'b1;
    cycles(8);
    fast_trip_in <= 1'b0;
    cycles(8);
    expect_out(5'h00);
    do_reset();
    for (int k = 0; k < 4; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      i_psw_pc_model.set_pins(1'b0, lfsr[1], lfsr[0]);
      cycles(8);
      expect_out({3'h0, lfsr[1:0]});
    end
    i_psw_pc_model.set_pins(1'b0, 1'b0, 1'b0);
    i_psw_pc_model.swap_pulse(SWAP_MIN_CYC - 100);
    cycles(8);
    expect_out(5'h00);
    i_psw_pc_model.swap_pulse(SWAP_MIN_CYC + 50);
    cycles(8);
    expect_out(5'h18);
    i_psw_pc_model.set_pins(1'b1, 1'b0, 1'b0);
    cycles(8);
    expect_out(5'h18);
    i_psw_pc_model.set_pins(1'b0, 1'b0, 1'b0);
    cycles(8);
    expect_out(5'h00);
    cycles(SWAP_ON_CYC);
    expect_out(5'h00);
    reverse_voltage_in <= 1'b1;
    i_psw_pc_model.swap_pulse(SWAP_MIN_CYC + 50);
    cycles(8);
    expect_out(5'h00);
    reverse_voltage_in <= 1'b0;
    cycles(8);
    expect_out(5'h18);
    cycles(4);
    check_val({4'h0, fl}, 5'h01);
    print_verdict();
  end
endmodule
